// *** src/ppst_pkg.sv ***
package ppst_pkg;

  // ==========================================================================
  // line counts and widths
  localparam int NUM_FP = 3;   // front panel programmable lines
  localparam int NUM_TRIG = 8; // backplane trigger lines
  localparam int NUM_STAR = 13; // backplane star trigger lines
  localparam int NUM_LINES = NUM_FP + NUM_TRIG + NUM_STAR;
  localparam int SEL_W = 5;
  localparam int SEC_W = 32;
  localparam int FRAC_W = 32;   // ns within the second
  localparam int ACC_W = 40;    // rate accumulator, ns with 8 fraction bits

  // ==========================================================================
  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SEC_NS = 1_000_000_000;
  localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
  // output clock granularity, period and high time multiples of this
  localparam int OUT_GRAIN_NS = 10;
  // nominal step per clock, ns with 8 fraction bits
  localparam logic [ACC_W-1:0] STEP_NOM = ACC_W'(CLK_PERIOD_NS * 256);
  localparam int RATE_SHIFT = 4; // damping of rate correction

  // ==========================================================================
  // reset values
  localparam logic [SEC_W-1:0] SEC_RST = 32'h0000_0000;
  localparam logic [SEL_W-1:0] SEL_RST = 5'h00;

  // ==========================================================================
  // line selection encoding: 0..2 front panel, 3..10 trigger, 11..23 star
  localparam logic [SEL_W-1:0] SEL_TRIG_BASE = SEL_W'(NUM_FP);
  localparam logic [SEL_W-1:0] SEL_STAR_BASE = SEL_W'(NUM_FP + NUM_TRIG);

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [SEC_W-1:0] sec;
    logic [FRAC_W-1:0] ns;
  } ppst_time_t;

  typedef struct packed {
    logic enable;         // synchronization running
    logic use_user_time;  // load user time else host time
    logic [SEL_W-1:0] in_sel;
    logic out_en;
    logic [SEL_W-1:0] out_sel;
  } ppst_cfg_t;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_FIRST, ST_LOCKED} ppst_state_t;

endpackage : ppst_pkg

// *** src/ppst_timebase.sv ***
`timescale 1ns/10ps
module ppst_timebase (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // configuration
  input wire ppst_pkg::ppst_cfg_t i_cfg,
  input wire ppst_pkg::ppst_time_t i_user_time,
  input wire ppst_pkg::ppst_time_t i_host_time,
  // trigger lines in
  input wire logic [ppst_pkg::NUM_LINES-1:0] i_line,
  // trigger lines out
  output logic [ppst_pkg::NUM_LINES-1:0] o_line,
  output logic [ppst_pkg::NUM_LINES-1:0] o_line_oe,
  // time and status
  output ppst_pkg::ppst_time_t o_time,
  output ppst_pkg::ppst_time_t o_stamp,
  output logic o_stamp_valid,
  output logic o_locked
);
  import ppst_pkg::*;

  // ==========================================================================
  // input synchronizers
  logic [NUM_LINES-1:0] sync1_r; // first stage, read only by sync2
  logic [NUM_LINES-1:0] sync2_r; // second stage
  logic pps_d_r;                 // selected line delayed for edge
  logic pps_sel;
  logic pps_evt;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= i_line;
      sync2_r <= sync1_r;
    end
  end

  assign pps_sel = (i_cfg.in_sel < SEL_W'(NUM_LINES)) ? sync2_r[i_cfg.in_sel] : 1'b0;

  // edge history of the selected line
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      pps_d_r <= 1'b0;
    end else begin
      pps_d_r <= pps_sel;
    end
  end

  assign pps_evt = pps_sel & ~pps_d_r & i_cfg.enable;

  // ==========================================================================
  // state machine
  ppst_state_t state_r;

  // sequence idle, wait first pulse, locked
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (i_cfg.enable) begin
            state_r <= ST_WAIT_FIRST;
          end
        end
        ST_WAIT_FIRST: begin
          if (!i_cfg.enable) begin
            state_r <= ST_IDLE;
          end else if (pps_evt) begin
            state_r <= ST_LOCKED;
          end
        end
        ST_LOCKED: begin
          if (!i_cfg.enable) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // period measurement and rate
  logic [31:0] cyc_cnt_r;         // cycles since last pulse
  logic [ACC_W-1:0] step_r;       // ns per clock, 8 fraction bits
  logic [ACC_W-1:0] step_ideal;   // step that makes this period one second
  logic [ACC_W-1:0] step_nxt;

  // ideal step, guarded against a zero count
  function automatic logic [ACC_W-1:0] ppst_ideal(input logic [31:0] cyc);
    logic [ACC_W+8:0] num;
    num = (ACC_W+9)'(SEC_NS) << 8;
    ppst_ideal = (cyc == 32'h0) ? STEP_NOM : ACC_W'(num / (ACC_W+9)'(cyc));
  endfunction : ppst_ideal

  assign step_ideal = ppst_ideal(cyc_cnt_r + 32'h1);
  assign step_nxt = step_r + ACC_W'((ACC_W+1)'($signed({1'b0, step_ideal}) -
                    $signed({1'b0, step_r})) >>> RATE_SHIFT);

  // cycles between pulses
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || pps_evt) begin
      cyc_cnt_r <= 32'h0;
    end else if (cyc_cnt_r != 32'hffff_ffff) begin
      cyc_cnt_r <= cyc_cnt_r + 32'h1;
    end
  end

  // rate update on each locked pulse
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      step_r <= STEP_NOM;
    end else if (pps_evt && state_r == ST_LOCKED) begin
      step_r <= step_nxt;
    end
  end

  // ==========================================================================
  // timebase counter
  ppst_time_t time_r;
  logic [7:0] frac_r;                // sub-ns fraction
  logic [ACC_W-1:0] ns_sum;
  logic sec_wrap;
  logic snap_up;                     // pulse in upper half starts a new second

  assign ns_sum = {time_r.ns, frac_r} + step_r;
  assign snap_up = time_r.ns >= FRAC_W'(SEC_NS / 2);
  assign sec_wrap = ns_sum[ACC_W-1:8] >= FRAC_W'(SEC_NS);

  // time keeping, load and boundary snap
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      time_r <= '{sec: SEC_RST, ns: '0};
      frac_r <= 8'h00;
    end else if (pps_evt && state_r == ST_WAIT_FIRST) begin
      time_r <= i_cfg.use_user_time ? i_user_time : i_host_time;
      frac_r <= 8'h00;
    end else if (pps_evt && state_r == ST_LOCKED) begin
      time_r.sec <= snap_up ? time_r.sec + SEC_W'(1) : time_r.sec;
      time_r.ns <= '0;
      frac_r <= 8'h00;
    end else if (sec_wrap) begin
      time_r.sec <= time_r.sec + SEC_W'(1);
      time_r.ns <= ns_sum[ACC_W-1:8] - FRAC_W'(SEC_NS);
      frac_r <= ns_sum[7:0];
    end else begin
      time_r.ns <= ns_sum[ACC_W-1:8];
      frac_r <= ns_sum[7:0];
    end
  end

  // ==========================================================================
  // timestamp capture
  // stamp on external edge
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_stamp <= '0;
      o_stamp_valid <= 1'b0;
    end else begin
      o_stamp_valid <= pps_evt;
      if (pps_evt) begin
        o_stamp <= time_r;
      end
    end
  end

  // ==========================================================================
  // pps output
  logic pps_out_r;
  logic boundary;

  // a late pulse snaps back inside the same second, already toggled at the wrap
  assign boundary = (state_r == ST_LOCKED) && (pps_evt ? snap_up : sec_wrap);

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      pps_out_r <= 1'b0;
    end else if (!i_cfg.out_en) begin
      pps_out_r <= 1'b0;
    end else if (boundary) begin
      pps_out_r <= ~pps_out_r;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_line <= '0;
      o_line_oe <= '0;
    end else begin
      for (int i = 0; i < NUM_LINES; i++) begin
        o_line[i] <= pps_out_r && (i_cfg.out_sel == SEL_W'(i));
        o_line_oe[i] <= i_cfg.out_en && (i_cfg.out_sel == SEL_W'(i));
      end
    end
  end

  // ==========================================================================
  // status outputs
  assign o_time = time_r;
  assign o_locked = (state_r == ST_LOCKED);

endmodule : ppst_timebase

// *** test/pps_disciplined_timebase_tb_top.sv ***
`timescale 1ns/10ps
// =====================================
// bench top
module pps_disciplined_timebase_tb_top;
  import ppst_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic run = 1'b0;
  ppst_cfg_t cfg = '0;
  ppst_time_t ut = '0;
  ppst_time_t ht = '0;
  logic [NUM_LINES-1:0] line, o_line, o_oe;
  ppst_time_t o_time, o_stamp;
  logic vld, lck;
  int n_fail = 0;
  int cmp_count = 0;
  logic [31:0] xs_s = 32'h1; // xorshift state
  localparam int PER = 1000; // partner pulse period in clocks
  // reference clock made by the bench
  initial forever #20 i_clk_sys = ~i_clk_sys;
  ppst_pps_src #(.PERIOD(PER)) u_ppst_pps_src (.i_clk_sys(i_clk_sys), .i_run(run),
    .i_sel(cfg.in_sel), .o_line(line));
  ppst_timebase u_ppst_timebase (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_cfg(cfg),
    .i_user_time(ut), .i_host_time(ht), .i_line(line), .o_line(o_line), .o_line_oe(o_oe),
    .o_time(o_time), .o_stamp(o_stamp), .o_stamp_valid(vld), .o_locked(lck));
  function automatic logic [31:0] xs();
    xs_s ^= xs_s << 13;
    xs_s ^= xs_s >> 17;
    xs_s ^= xs_s << 5;
    return xs_s;
  endfunction : xs
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  // bounded wait for one stamp event
  task automatic wait_vld(output bit got);
    got = 0;
    for (int i = 0; i < 2000 && !got; i++) begin
      @(posedge i_clk_sys);
      #1 got = (vld === 1'b1);
    end
  endtask : wait_vld
  // one synchronisation run against an integer model of sec, ns and step
  task automatic run_pass(input logic [SEL_W-1:0] sel, input bit en, input bit usr,
    input bit big, input bit oe);
    bit got;
    bit lvl;
    ppst_time_t ld;
    logic [SEL_W-1:0] osel;
    logic [SEC_W-1:0] msec;
    longint step;
    longint mns;
    osel = SEL_W'(xs() % NUM_LINES);
    ld = {xs(), big ? 32'h3b9a_0000 : 32'h0000_1000};
    msec = ld.sec;
    step = longint'(STEP_NOM);
    lvl = 1'b0;
    @(posedge i_clk_sys);
    i_rst_b <= 1'b0;
    run <= 1'b0;
    ut <= usr ? ld : ~ld;
    ht <= usr ? ~ld : ld;
    cfg <= '{en, usr, sel, oe, osel};
    repeat (6) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    run <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      wait_vld(got);
      // refused: disabled or out-of-range line selection
      if (!en || sel >= SEL_W'(NUM_LINES)) begin
        check(got, 1'b0);
        check(lck, 1'b0);
        return;
      end
      if (!got) begin
        n_fail++;
        return;
      end
      check(lck, 1'b1);
      if (k == 0) begin
        check(o_time, ld);
      end else begin
        // stamp is the time PER-1 steps after the last load or snap
        mns = ((k == 1) ? longint'(ld.ns) : 0) + (((PER - 1) * step) >>> 8);
        check(o_stamp, {msec, 32'(mns)});
        if (mns >= SEC_NS / 2) begin
          msec++;
          lvl = ~lvl;
        end
        check(o_time, {msec, 32'h0});
        step = step + ((longint'(SEC_NS) * 256 / PER - step) >>> RATE_SHIFT);
      end
      check(o_oe, oe ? 64'(1) << osel : 64'(0));
      @(posedge i_clk_sys);
      #1 check(o_line, (oe && lvl) ? 64'(1) << osel : 64'(0));
      check(o_time.ns, ((k == 0) ? ld.ns : 32'h0) + 32'(step >>> 8));
    end
  endtask : run_pass
  initial begin
    run_pass(5'd2, 1'b0, 1'b1, 1'b0, 1'b1);
    run_pass(5'd2, 1'b1, 1'b1, 1'b0, 1'b1);
    run_pass(5'd10, 1'b1, 1'b0, 1'b1, 1'b1);
    run_pass(5'd23, 1'b1, 1'b1, 1'b1, 1'b0);
    run_pass(5'(xs() % 24), 1'b1, 1'b0, 1'b0, 1'b1);
    run_pass(5'd24, 1'b1, 1'b1, 1'b0, 1'b1);
    summarize();
  end
endmodule : pps_disciplined_timebase_tb_top
bind ppst_timebase ppst_timebase_monitor u_mon (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
  .i_cfg(i_cfg), .i_user_time(i_user_time), .i_host_time(i_host_time), .o_line(o_line),
  .o_line_oe(o_line_oe), .o_time(o_time), .o_stamp(o_stamp),
  .o_stamp_valid(o_stamp_valid), .o_locked(o_locked));

// *** test/ppst_pps_src.sv ***
`timescale 1ns/10ps
// =====================================
// far side: pulse source on one line
module ppst_pps_src #(
  parameter int PERIOD = 1000
) (
  // clock and control
  input wire logic i_clk_sys,
  input wire logic i_run,
  input wire logic [ppst_pkg::SEL_W-1:0] i_sel,
  // trigger lines to the block
  output logic [ppst_pkg::NUM_LINES-1:0] o_line
);
  import ppst_pkg::*;
  int cnt = 0; // position within the pulse period
  logic [NUM_LINES-1:0] churn = '0; // toggling pattern for idle lines
  logic [NUM_LINES-1:0] nxt; // next line levels
  always @(posedge i_clk_sys) begin
    cnt <= i_run ? (cnt + 1) % PERIOD : 0;
    churn <= ~churn;
    nxt = ~churn; // unselected lines churn
    nxt[i_sel] = i_run && cnt >= 100 && cnt < 104;
    o_line <= nxt;
  end
endmodule : ppst_pps_src

// *** test/ppst_timebase_monitor.sv ***
`timescale 1ns/10ps
// =====================================
// port checker for the timebase
module ppst_timebase_monitor (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // watched ports
  input wire ppst_pkg::ppst_cfg_t i_cfg,
  input wire ppst_pkg::ppst_time_t i_user_time,
  input wire ppst_pkg::ppst_time_t i_host_time,
  input wire logic [ppst_pkg::NUM_LINES-1:0] o_line,
  input wire logic [ppst_pkg::NUM_LINES-1:0] o_line_oe,
  input wire ppst_pkg::ppst_time_t o_time,
  input wire ppst_pkg::ppst_time_t o_stamp,
  input wire logic o_stamp_valid,
  input wire logic o_locked
);
  import ppst_pkg::*;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  sequence s_snap;
    o_stamp_valid && $past(o_locked);
  endsequence
  AST_VALID_PULSE: assert property (o_stamp_valid |=> (!o_stamp_valid)[*2])
    else $error("stamp valid too long");
  AST_LOAD: assert property ($rose(o_locked) |-> o_stamp_valid && o_time ==
    (i_cfg.use_user_time ? i_user_time : i_host_time))
    else $error("bad initial load");
  AST_SNAP: assert property (s_snap |-> o_time.ns == 32'h0 && o_time.sec ==
    o_stamp.sec + 32'(o_stamp.ns >= 32'(SEC_NS / 2)))
    else $error("bad seconds snap");
  AST_STAMP_HOLD: assert property (!o_stamp_valid |-> $stable(o_stamp))
    else $error("stamp moved");
  AST_TIME_ADV: assert property (o_locked && $past(o_locked) && !o_stamp_valid &&
    o_time.ns != 32'h0 |->
    (o_time.sec == $past(o_time.sec) && o_time.ns > $past(o_time.ns)) ||
    (o_time.sec == $past(o_time.sec) + 32'h1 && o_time.ns < $past(o_time.ns)))
    else $error("time not advancing");
  AST_OE_OFF: assert property (!$past(i_cfg.out_en) |-> o_line_oe == '0)
    else $error("drive while off");
  AST_TOGGLE: assert property ($changed(o_line) |-> $past(o_locked))
    else $error("output moved unlocked");
  AST_STAMP_EN: assert property (o_stamp_valid |-> $past(i_cfg.enable))
    else $error("event while disabled");
endmodule : ppst_timebase_monitor
